// File: verilog/ptm_defines.svh
// Constants of the program trace message generator: codes, widths, counts.
// Assumes inclusion by bare name from the design file.
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH
`define PTM_TCODE_DIRECT      6'h03
`define PTM_TCODE_INDIRECT    6'h04
`define PTM_TCODE_ERROR       6'h08
`define PTM_TCODE_SYNC        6'h09
`define PTM_TCODE_DIRECT_SYNC 6'h0B
`define PTM_TCODE_DIRECT_TGT  6'h39
`define PTM_ECODE_OVERRUN     5'h01
`define PTM_EVT_EXCEPTION     2'h3
`define PTM_EVT_CALL          2'h2
`define PTM_EVT_REGISTER      2'h1
`define PTM_EVT_RETURN        2'h0
`define PTM_SYNC_PERIOD       256
`define PTM_COUNT_COMPACT     8'h02
`define PTM_COUNT_EXTENDED    8'h04
`define PTM_FIFO_DEPTH        16
`endif

// File: verilog/ptm_pkg.sv
// Types shared by the program trace message generator, the debugger model and the bench.
// Assumes the constants header is on the include path.
package ptm_pkg;
    // Kind of program flow change reported by the core for one retired instruction.
    typedef enum logic [2:0] {
        PTM_FLOW_NONE     = 3'b000,
        PTM_FLOW_DIRECT   = 3'b001,
        PTM_FLOW_EXCEPT   = 3'b010,
        PTM_FLOW_CALL     = 3'b011,
        PTM_FLOW_REGWRITE = 3'b100,
        PTM_FLOW_RETURN   = 3'b101
    } ptm_flow_e;

    // One retired instruction as seen by the trace unit.
    typedef struct packed {
        logic      valid;
        logic      extended;
        ptm_flow_e flow;
        logic [31:0] pc;
        logic [31:0] target;
    } ptm_retire_s;

    // One outgoing message; addr_bits gives how many address bits are significant.
    typedef struct packed {
        logic [5:0]  tcode;
        logic [31:0] addr;
        logic [5:0]  addr_bits;
        logic [7:0]  icnt;
        logic [1:0]  evt_id;
        logic [4:0]  ecode;
    } ptm_msg_s;

    // Emission states: an overrun error is followed by its sync message.
    typedef enum logic [1:0] {
        PTM_ST_RUN   = 2'b00,
        PTM_ST_ERROR = 2'b01,
        PTM_ST_SYNC  = 2'b10
    } ptm_state_e;
endpackage

// File: verilog/ptm_trace_gen.sv
// Program trace message generator with its output FIFO.
// Assumes one retired instruction per cycle at most, all inputs synchronous to CLK.
`timescale 1ns/100ps
`include "ptm_defines.svh"

// Message FIFO; the drain side may stall, and full refuses writes honestly.
module ptm_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage array.
    logic [AW-1:0]    wr_ptr_reg;    // Write index.
    logic [AW-1:0]    rd_ptr_reg;    // Read index.
    logic [AW:0]      count_reg;     // Number of words held.
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write; no reset needed because count guards reads.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointer and occupancy tracking.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Function
// [R1] Target-address mode: direct branch sends code 57
// [R2] Calls, returns, interrupts, exceptions send indirect messages
// [R3] Compressed address: XOR with last sent, strip zeros
// [R4] Exception entry events use identifier 3
// [R5] Subroutine calls use identifier 2
// [R6] Register writes to PC use identifier 1
// [R7] Returns use identifier 0
// [R8] Indirect message: address, count, identifier, code 4
// [R9] Sync after leaving reset
// [R10] Sync when trace becomes enabled
// [R11] Sync on leaving power-down
// [R12] Sync on leaving debug mode
// [R13] Overrun: error code 8, then sync
// [R14] Sync on event input when selected
// [R15] Sync on byte counter overflow
// [R16] Sync after 256 unsynced branch messages
// [R17] Sync message: full PC, count, code 9
// [R18] Sync on direct branch becomes direct-with-sync
// [R19] Direct-with-sync: full target, count, code 11
// [R20] Only retired instructions traced, no speculation
// [R21] Count field holds bytes since last branch
// [R22] Plain direct branch: count and code 3
// [R23] Compact adds two, extended adds four
// [R24] Byte counter clears on each message; code clears it on branch messages only, a sync loads the step
// [R25] Debugger sets trace mode bit 2 first
module ptm_trace_gen #(
    parameter int SYNC_PERIOD = `PTM_SYNC_PERIOD,
    parameter int FIFO_DEPTH  = `PTM_FIFO_DEPTH
) (
    input  wire logic                CLK,
    input  wire logic                NRST,
    input  wire ptm_pkg::ptm_retire_s RETIRE,
    input  wire logic                TRACE_MODE_FIELD_2,
    input  wire logic                TARGET_ADDR_TRACE_ENABLE,
    input  wire logic                EVENT_INPUT_PIN,
    input  wire logic                EVENT_INPUT_SYNC_SEL,
    input  wire logic                DEBUG_MODE,
    input  wire logic                POWER_DOWN,
    output logic                     MSG_VALID,
    input  wire logic                MSG_READY,
    output ptm_pkg::ptm_msg_s        MSG,
    output logic                     OVERRUN
);
    localparam int MW = $bits(ptm_pkg::ptm_msg_s);

    logic        rst_meta_reg;        // First reset release stage.
    logic        rst_n;               // Released reset copy.
    logic        trace_on;            // Tracing allowed this cycle.
    logic        en_prev_reg;         // Trace active last cycle.
    logic        dbg_prev_reg;        // Debug mode last cycle.
    logic        pd_prev_reg;         // Power-down last cycle.
    logic        evt_prev_reg;        // Event input last cycle.
    logic        sync_pend_reg;       // A sync is owed.
    logic        lost_reg;            // A message was dropped for lack of room.
    logic [7:0]  icnt_reg;            // Bytes executed since last message.
    logic [8:0]  branch_cnt_reg;      // Unsynced branch messages sent.
    logic [31:0] last_addr_reg;       // Last transmitted address.
    ptm_pkg::ptm_state_e state_reg;   // Emission state.
    ptm_pkg::ptm_msg_s   msg_next;    // Message built this cycle.
    logic        msg_fire;            // Message built this cycle.
    logic        fifo_ready;          // FIFO has room.
    logic        fifo_valid;          // FIFO holds a message.
    logic [MW-1:0] fifo_out;          // FIFO head.
    logic        sync_cause;          // A sync condition arises now.
    logic        overflow;            // Byte counter would overflow.
    logic [7:0]  step;                // Bytes this instruction adds.
    logic        is_branch;
    logic        is_indirect;
    logic        out_valid_reg;       // Output stage valid.
    ptm_pkg::ptm_msg_s out_msg_reg;   // Output stage message.
    logic        overrun_reg;         // Overrun flag for the output pin.

    // Reset release through two flip-flops so all logic leaves reset together.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Leading-zero strip: count of significant bits in an address.
    function automatic logic [5:0] sig_bits(input logic [31:0] a);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (a[i]) begin
                n = 6'(i + 1);
            end
        end
        return n;
    endfunction

    // Maps a flow kind to its event identifier.
    function automatic logic [1:0] evt_code(input ptm_pkg::ptm_flow_e f);
        case (f)
            ptm_pkg::PTM_FLOW_EXCEPT:   evt_code = `PTM_EVT_EXCEPTION;   // R4
            ptm_pkg::PTM_FLOW_CALL:     evt_code = `PTM_EVT_CALL;        // R5
            ptm_pkg::PTM_FLOW_REGWRITE: evt_code = `PTM_EVT_REGISTER;    // R6
            default:                    evt_code = `PTM_EVT_RETURN;      // R7
        endcase
    endfunction

    // Trace runs only with the mode bit set and outside debug mode and power-down.
    assign trace_on    = TRACE_MODE_FIELD_2 && !DEBUG_MODE && !POWER_DOWN; // R25
    assign is_branch   = RETIRE.valid && trace_on && (RETIRE.flow != ptm_pkg::PTM_FLOW_NONE); // R20
    assign is_indirect = is_branch && (RETIRE.flow != ptm_pkg::PTM_FLOW_DIRECT);
    assign step        = RETIRE.extended ? `PTM_COUNT_EXTENDED : `PTM_COUNT_COMPACT; // R23
    assign overflow    = RETIRE.valid && trace_on && !is_branch
                         && ({1'b0, icnt_reg} + {1'b0, step} > 9'h0FF);
    assign sync_cause  = (trace_on && !en_prev_reg && !dbg_prev_reg && !pd_prev_reg) // R10
                         || (dbg_prev_reg && !DEBUG_MODE)                            // R12
                         || (pd_prev_reg && !POWER_DOWN)                              // R11
                         || (EVENT_INPUT_PIN && !evt_prev_reg && EVENT_INPUT_SYNC_SEL) // R14
                         || overflow                                                  // R15
                         || (branch_cnt_reg >= 9'(SYNC_PERIOD));                      // R16

    // Message builder; one message at most per cycle, chosen by priority.
    always_comb begin
        msg_next = '0;
        msg_fire = 1'b0;
        msg_next.icnt = icnt_reg; // R21
        if (state_reg == ptm_pkg::PTM_ST_ERROR) begin
            msg_next.tcode = `PTM_TCODE_ERROR; // R13
            msg_next.ecode = `PTM_ECODE_OVERRUN;
            msg_fire       = 1'b1;
        end else if (!trace_on) begin
            msg_fire = 1'b0;
        end else if (is_indirect) begin
            msg_next.tcode     = `PTM_TCODE_INDIRECT; // R2 R8
            msg_next.addr      = RETIRE.target ^ last_addr_reg; // R3
            msg_next.addr_bits = sig_bits(RETIRE.target ^ last_addr_reg);
            msg_next.evt_id    = evt_code(RETIRE.flow);
            msg_fire           = 1'b1;
        end else if (is_branch && (sync_pend_reg || sync_cause)) begin
            msg_next.tcode     = `PTM_TCODE_DIRECT_SYNC; // R18 R19
            msg_next.addr      = RETIRE.target;
            msg_next.addr_bits = sig_bits(RETIRE.target);
            msg_fire           = 1'b1;
        end else if (is_branch && TARGET_ADDR_TRACE_ENABLE) begin
            msg_next.tcode     = `PTM_TCODE_DIRECT_TGT; // R1
            msg_next.addr      = RETIRE.target ^ last_addr_reg; // R3
            msg_next.addr_bits = sig_bits(RETIRE.target ^ last_addr_reg);
            msg_fire           = 1'b1;
        end else if (is_branch) begin
            msg_next.tcode = `PTM_TCODE_DIRECT; // R22
            msg_fire       = 1'b1;
        end else if (RETIRE.valid && (sync_pend_reg || sync_cause)) begin
            msg_next.tcode     = `PTM_TCODE_SYNC; // R9 R17
            msg_next.addr      = RETIRE.pc;
            msg_next.addr_bits = sig_bits(RETIRE.pc);
            msg_fire           = 1'b1;
        end
    end

    // Edge history of the sync sources.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            en_prev_reg  <= 1'b0;
            dbg_prev_reg <= 1'b0;
            pd_prev_reg  <= 1'b0;
            evt_prev_reg <= 1'b0;
        end else begin
            en_prev_reg  <= trace_on;
            dbg_prev_reg <= DEBUG_MODE;
            pd_prev_reg  <= POWER_DOWN;
            evt_prev_reg <= EVENT_INPUT_PIN;
        end
    end

    // Overrun state: a dropped message forces error then sync, set winning over clear.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ptm_pkg::PTM_ST_RUN;
            lost_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ptm_pkg::PTM_ST_RUN: begin
                    if (msg_fire && !fifo_ready) begin
                        lost_reg  <= 1'b1;
                        state_reg <= ptm_pkg::PTM_ST_ERROR; // R13
                    end
                end
                ptm_pkg::PTM_ST_ERROR: begin
                    if (fifo_ready) begin
                        lost_reg  <= 1'b0;
                        state_reg <= ptm_pkg::PTM_ST_SYNC;
                    end
                end
                ptm_pkg::PTM_ST_SYNC: begin
                    state_reg <= ptm_pkg::PTM_ST_RUN;
                end
                default: begin
                    state_reg <= ptm_pkg::PTM_ST_RUN;
                end
            endcase
        end
    end

    // Sync pending: set at reset and on causes, cleared when a sync-bearing message goes out.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync_pend_reg <= 1'b1; // R9
        end else if (state_reg == ptm_pkg::PTM_ST_SYNC) begin
            sync_pend_reg <= 1'b1; // R13
        end else if (msg_fire && fifo_ready && state_reg == ptm_pkg::PTM_ST_RUN
                     && (msg_next.tcode == `PTM_TCODE_SYNC
                         || msg_next.tcode == `PTM_TCODE_DIRECT_SYNC)) begin
            sync_pend_reg <= 1'b0;
        end else if (sync_cause) begin
            sync_pend_reg <= 1'b1;
        end
    end

    // Byte counter, branch counter and last address; the counter restarts on each message accepted in the run state.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            icnt_reg       <= 8'h00;
            branch_cnt_reg <= 9'h000;
            last_addr_reg  <= 32'h0000_0000;
        end else if (msg_fire && fifo_ready && state_reg == ptm_pkg::PTM_ST_RUN) begin
            icnt_reg <= is_branch ? 8'h00 : step; // R24
            if (msg_next.tcode == `PTM_TCODE_SYNC || msg_next.tcode == `PTM_TCODE_DIRECT_SYNC) begin
                branch_cnt_reg <= 9'h000;
                last_addr_reg  <= (msg_next.tcode == `PTM_TCODE_SYNC) ? RETIRE.pc : RETIRE.target;
            end else begin
                branch_cnt_reg <= branch_cnt_reg + 9'h001; // R16
                if (msg_next.addr_bits != 6'h00 || msg_next.tcode != `PTM_TCODE_DIRECT) begin
                    last_addr_reg <= RETIRE.target;
                end
            end
        end else if (RETIRE.valid && trace_on && !is_branch) begin
            icnt_reg <= icnt_reg + step; // R23
        end
    end

    ptm_fifo #(
        .WIDTH (MW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst_n     (rst_n),
        .in_valid  (msg_fire),
        .in_ready  (fifo_ready),
        .in_data   (msg_next),
        .out_valid (fifo_valid),
        .out_ready (!out_valid_reg || MSG_READY),
        .out_data  (fifo_out)
    );

    // Output stage so every output comes from a flip-flop.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_msg_reg   <= '0;
            overrun_reg   <= 1'b0;
        end else begin
            if (!out_valid_reg || MSG_READY) begin
                out_valid_reg <= fifo_valid;
                out_msg_reg   <= fifo_out;
            end
            overrun_reg <= lost_reg;
        end
    end

    assign MSG_VALID = out_valid_reg;
    assign MSG       = out_msg_reg;
    assign OVERRUN   = overrun_reg;

    // An accepted error message is always followed by the sync state, then a sync owed.
    error_sync_a: assert property (@(posedge CLK) disable iff (!rst_n) // R13
        state_reg == ptm_pkg::PTM_ST_ERROR && fifo_ready |=> state_reg == ptm_pkg::PTM_ST_SYNC
        ##1 sync_pend_reg) else $error("Overrun error not followed by sync.");
    // Indirect message carries code 4 and the right identifier.
    indirect_fmt_a: assert property (@(posedge CLK) disable iff (!rst_n) // R8
        msg_fire && is_indirect && state_reg == ptm_pkg::PTM_ST_RUN |->
        msg_next.tcode == 6'h04 && msg_next.evt_id == evt_code(RETIRE.flow))
        else $error("Indirect message malformed.");
    // Byte counter clears after an accepted branch message.
    icnt_clear_a: assert property (@(posedge CLK) disable iff (!rst_n) // R24
        msg_fire && fifo_ready && is_branch && state_reg == ptm_pkg::PTM_ST_RUN
        |=> icnt_reg == 8'h00) else $error("Byte counter not cleared.");
    // Sequential instructions add their size.
    icnt_step_a: assert property (@(posedge CLK) disable iff (!rst_n) // R23
        RETIRE.valid && trace_on && !is_branch && !msg_fire
        |=> icnt_reg == $past(icnt_reg) + ($past(RETIRE.extended) ? 8'h04 : 8'h02))
        else $error("Byte counter step wrong.");
    // Leaving debug mode owes a sync.
    debug_exit_a: assert property (@(posedge CLK) disable iff (!rst_n) // R12
        dbg_prev_reg && !DEBUG_MODE && !msg_fire |=> sync_pend_reg)
        else $error("No sync owed after debug exit.");
    // Direct branch with sync replaces a pending sync.
    direct_sync_a: assert property (@(posedge CLK) disable iff (!rst_n) // R18
        is_branch && !is_indirect && sync_pend_reg && state_reg == ptm_pkg::PTM_ST_RUN
        |-> msg_next.tcode == 6'h0B) else $error("Direct-with-sync not chosen.");
    // Target-address mode replaces plain direct messages.
    target_mode_a: assert property (@(posedge CLK) disable iff (!rst_n) // R1
        is_branch && !is_indirect && !sync_pend_reg && !sync_cause && TARGET_ADDR_TRACE_ENABLE
        && state_reg == ptm_pkg::PTM_ST_RUN |-> msg_next.tcode == 6'h39)
        else $error("Target address message not chosen.");
    // No message without trace enabled while in the run state.
    trace_gate_a: assert property (@(posedge CLK) disable iff (!rst_n) // R25
        !trace_on && state_reg == ptm_pkg::PTM_ST_RUN |-> !msg_fire)
        else $error("Message while trace disabled.");
endmodule

// File: sim/ptm_debugger_model.sv
// Debugger model that drains trace messages from the generator.
// Assumes one clock and a stall level driven by the testbench.
`timescale 1ns/100ps

module ptm_debugger_model (
    input  wire logic              clk,
    input  wire logic              stall,
    input  wire logic              msg_valid,
    output logic                   msg_ready,
    input  wire ptm_pkg::ptm_msg_s msg
);
    // Every accepted message, oldest first.
    ptm_pkg::ptm_msg_s rx_q[$];

    // A stalled debugger refuses messages, so the FIFO can fill up.
    assign msg_ready = !stall;

    // Messages are taken only at an edge where both sides agree.
    always @(posedge clk) begin
        if (msg_valid && msg_ready) begin
            rx_q.push_back(msg);
        end
    end
endmodule

// File: sim/tb_ptm_trace_gen.sv
// Self-checking bench for the program trace message generator.
// Assumes the design is built with a short sync period of four branches.
`timescale 1ns/100ps

module tb_ptm_trace_gen;
    logic clk = 0, nrst = 0, tm2 = 1, tgt_en = 0, evt = 0, evt_sel = 1;
    logic dbg = 0, pwr = 0, stall = 0, ready, valid, ovr, ovr_seen = 0;
    ptm_pkg::ptm_retire_s ret = '0;
    ptm_pkg::ptm_msg_s    msg;
    int fails = 0, samples_checked = 0;

    // Half period of 10 ns gives the 50 MHz clock.
    always #10 clk = !clk;

    ptm_trace_gen #(.SYNC_PERIOD(4), .FIFO_DEPTH(16)) uut (
        .CLK(clk), .NRST(nrst), .RETIRE(ret), .TRACE_MODE_FIELD_2(tm2),
        .TARGET_ADDR_TRACE_ENABLE(tgt_en), .EVENT_INPUT_PIN(evt),
        .EVENT_INPUT_SYNC_SEL(evt_sel), .DEBUG_MODE(dbg), .POWER_DOWN(pwr),
        .MSG_VALID(valid), .MSG_READY(ready), .MSG(msg), .OVERRUN(ovr)
    );

    ptm_debugger_model dbgm (
        .clk(clk), .stall(stall), .msg_valid(valid), .msg_ready(ready), .msg(msg)
    );

    // The overrun flag drops once the FIFO has room again, so it is latched here.
    always @(posedge clk) begin
        if (ovr === 1'b1) begin
            ovr_seen <= 1'b1;
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // One retired instruction; inputs change 1 ns after an edge.
    // Valid stays up so back-to-back instructions need no gap; idle lowers it.
    task automatic step(input ptm_pkg::ptm_flow_e f, input logic ext, input logic [31:0] pc,
                        input logic [31:0] tgt, input logic v = 1'b1);
        ret = '{valid: v, extended: ext, flow: f, pc: pc, target: tgt};
        @(posedge clk);
        #1;
    endtask

    // Quiet cycles: no instruction retires while they run.
    task automatic idle(input int n);
        ret.valid = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Number of significant address bits once leading zeros are dropped.
    function automatic logic [31:0] sig_len(input logic [31:0] a);
        sig_len = 32'h0;
        for (int i = 0; i < 32; i++) if (a[i]) sig_len = 32'(i + 1);
    endfunction

    // Waits a bounded time for one message, then checks its fields.
    task automatic check_msg(input logic [5:0] tc, input logic [31:0] ad, input logic [7:0] ic,
                             input logic [1:0] ev, input logic ci);
        ptm_pkg::ptm_msg_s m;
        for (int i = 0; i < 50 && dbgm.rx_q.size() == 0; i++) idle(1);
        if (dbgm.rx_q.size() == 0) begin
            cmp(32'h0, 32'h1);
            return;
        end
        m = dbgm.rx_q.pop_front();
        cmp(32'(m.tcode), 32'(tc));
        cmp(m.addr, ad);
        cmp(32'(m.addr_bits), sig_len(ad));
        if (ci) cmp(32'(m.icnt), 32'(ic));
        if (tc == 6'h04) cmp(32'(m.evt_id), 32'(ev));
    endtask

    // Direct, indirect and target-address messages with counts and XOR addresses.
    task automatic t_branches();
        step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h100, 32'h200);
        check_msg(6'h0B, 32'h200, 8'h00, 0, 1);
        step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h200, 0);
        step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h202, 0);
        step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h204, 0);
        step(ptm_pkg::PTM_FLOW_NONE, 1, 32'h206, 0);
        step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h20A, 32'h999, 1'b0);
        step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h20A, 32'h300);
        check_msg(6'h03, 32'h0, 8'h0A, 0, 1);
        step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h300, 0);
        step(ptm_pkg::PTM_FLOW_CALL, 0, 32'h302, 32'h1000);
        step(ptm_pkg::PTM_FLOW_EXCEPT, 0, 32'h1000, 32'h80);
        step(ptm_pkg::PTM_FLOW_REGWRITE, 0, 32'h80, 32'h4000);
        check_msg(6'h04, 32'h1200, 8'h02, 2'h2, 1);
        check_msg(6'h04, 32'h1080, 8'h00, 2'h3, 1);
        check_msg(6'h04, 32'h4080, 8'h00, 2'h1, 1);
        step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h4000, 32'h4100);
        check_msg(6'h0B, 32'h4100, 8'h00, 0, 1);
        step(ptm_pkg::PTM_FLOW_RETURN, 0, 32'h4100, 32'h104);
        check_msg(6'h04, 32'h4004, 8'h00, 2'h0, 1);
        tgt_en = 1'b1;
        step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h104, 32'h140);
        check_msg(6'h39, 32'h044, 8'h00, 0, 1);
        tgt_en = 1'b0;
        $display("test branches done");
    endtask

    // Four sync causes in turn (debug exit, power-down exit, trace enable, event input), each followed by one sequential instruction.
    task automatic t_sync_causes();
        for (int c = 0; c < 4; c++) begin
            dbg = (c == 0);
            pwr = (c == 1);
            tm2 = (c != 2);
            evt = (c == 3);
            idle(3);
            {dbg, pwr, tm2, evt} = 4'h2;
            idle(2);
            step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h500 + 32'(c * 16), 0);
            check_msg(6'h09, 32'h500 + 32'(c * 16), 0, 0, 0);
        end
        $display("test sync causes done");
    endtask

    // A stalled debugger forces drops; an error then a sync must follow.
    task automatic t_overrun();
        int k;
        stall = 1'b1;
        for (int i = 0; i < 24; i++) step(ptm_pkg::PTM_FLOW_DIRECT, 0, 32'h600, 32'h600);
        idle(2);
        cmp(32'(ovr_seen), 32'h1);
        stall = 1'b0;
        // The owed sync rides on a retiring instruction, so one retires after the error.
        idle(3);
        step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h600, 0);
        idle(80);
        k = -1;
        foreach (dbgm.rx_q[i]) if (k < 0 && dbgm.rx_q[i].tcode === 6'h08) k = i;
        cmp(32'(k >= 0 && k + 1 < dbgm.rx_q.size()), 32'h1);
        if (k >= 0 && k + 1 < dbgm.rx_q.size()) begin
            cmp(32'(dbgm.rx_q[k].ecode), 32'h01);
            cmp(32'(dbgm.rx_q[k+1].tcode), 32'h09);
            cmp(dbgm.rx_q[k+1].addr, 32'h600);
        end
        dbgm.rx_q.delete();
        $display("test overrun done");
    endtask

    // 130 compact instructions overflow the 8-bit byte counter.
    task automatic t_count_overflow();
        int n;
        for (int i = 0; i < 130; i++) step(ptm_pkg::PTM_FLOW_NONE, 0, 32'h800 + 32'(2 * i), 0);
        idle(20);
        n = 0;
        foreach (dbgm.rx_q[i]) if (dbgm.rx_q[i].tcode === 6'h09) n++;
        cmp(32'(n > 0), 32'h1);
        $display("test count overflow done");
    endtask

    task automatic test_done();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence: trace mode bit is set before reset is released.
    initial begin
        idle(2);
        nrst = 1'b1;
        idle(4);
        t_branches();
        t_sync_causes();
        t_overrun();
        t_count_overflow();
        test_done();
    end

    // The tests need under 2000 cycles; this cuts a hang short.
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule
